// file: rtl/port_ctrl_defines.svh
// register offsets, field widths, reset values and bus constants for the port controller
`ifndef PORT_CTRL_DEFINES_SVH
`define PORT_CTRL_DEFINES_SVH

// ----------------------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define IDX_FIRST_LATCH 6'h00
`define IDX_SECOND_LATCH 6'h01
`define IDX_FIRST_DIR 6'h04
`define IDX_SECOND_DIR 6'h05
`define IDX_FIRST_INHIBIT 6'h10
`define IDX_SECOND_INHIBIT 6'h11

// ----------------------------------------------------------------------------
// field widths and reset values
// ----------------------------------------------------------------------------
`define FIRST_WIDTH 8
`define SECOND_WIDTH 2
`define FIRST_DIR_RESET 8'h00
`define SECOND_DIR_RESET 2'h0
`define FIRST_INHIBIT_RESET 8'h00
`define SECOND_INHIBIT_RESET 2'h0

// ----------------------------------------------------------------------------
// bus constants
// ----------------------------------------------------------------------------
`define BUS_READ_ZERO 32'h0000_0000
`define MIN_ADDR_WIDTH 7

`endif

// file: rtl/port_ctrl_pkg.sv
// types shared by the port controller
package port_ctrl_pkg;
    typedef logic [7:0] first_port_type;  // one bit per pin of the first port
    typedef logic [1:0] second_port_type; // one bit per pin of the second port
    typedef logic [5:0] reg_index_type;   // word index of a register
endpackage

// file: rtl/bidir_port_pulldown_ctrl.sv
// two bidirectional ports with direction, latch and pulldown-inhibit control over wishbone
//
// Chosen here: the Wishbone interface to the registers.
`include "port_ctrl_defines.svh"

module bidir_port_pulldown_ctrl
    import port_ctrl_pkg::*;
#(
    parameter int ADDR_WIDTH = 8,          // wishbone byte address width
    parameter bit PULLDOWN_MASK = 1'b0,    // 1 disables all pulldowns, 0 enables them
    parameter bit OSC3_OPTION = 1'b0       // 1 gives the upper second-port pin to the rc oscillator
) (
    input wire logic clk_i,                          // bus clock, 25 MHz
    input wire logic rst_i,                          // synchronous reset, active high
    input wire logic cyc_i,                          // wishbone cycle
    input wire logic stb_i,                          // wishbone strobe
    input wire logic we_i,                           // wishbone write enable
    input wire logic [ADDR_WIDTH-1:0] adr_i,         // wishbone byte address
    input wire logic [3:0] sel_i,                    // wishbone byte selects
    input wire logic [31:0] dat_i,                   // wishbone write data
    output logic [31:0] dat_o,                       // wishbone read data
    output logic ack_o,                              // wishbone acknowledge
    input wire logic [7:0] first_port_pins_i,        // first port pin levels
    output logic [7:0] first_port_pins_o,            // first port pin drive values
    output logic [7:0] first_port_pins_oe_o,         // first port output enables
    output logic [7:0] first_port_pulldown_en_o,     // first port pulldown enables
    input wire logic second_port_pin_low_i,          // lower second-port pin level
    output logic second_port_pin_low_o,              // lower second-port drive value
    output logic second_port_pin_low_oe_o,           // lower second-port output enable
    input wire logic second_port_pin_high_osc_out_i, // upper second-port pin level
    output logic second_port_pin_high_osc_out_o,     // upper second-port drive value
    output logic second_port_pin_high_osc_out_oe_o,  // upper second-port output enable
    output logic [1:0] second_port_pulldown_en_o,    // second port pulldown enables
    input wire logic osc_drive_i                     // rc oscillator output to place on the upper pin
);

    // ------------------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------------------
    // the highest register needs seven address bits
    if (ADDR_WIDTH < `MIN_ADDR_WIDTH || ADDR_WIDTH > 32) begin : g_bad_addr
        $error("address width cannot reach every register");
    end
    // the package types must match the header widths
    if ($bits(first_port_type) != `FIRST_WIDTH) begin : g_bad_first
        $error("first port type width mismatch");
    end
    if ($bits(second_port_type) != `SECOND_WIDTH) begin : g_bad_second
        $error("second port type width mismatch");
    end

    // ------------------------------------------------------------------------
    // storage
    // ------------------------------------------------------------------------
    first_port_type first_port_latch;                 // first port data latch, not reset
    second_port_type second_port_latch;               // second port data latch, not reset
    first_port_type first_port_dir_bits;              // first port direction
    second_port_type second_port_dir;                 // second port direction
    first_port_type first_port_inhibit_bits;          // first port pulldown inhibit
    second_port_type second_port_inhibit;             // second port pulldown inhibit
    first_port_type first_sync_a;                     // first synchroniser stage, first port
    first_port_type first_sync;                       // synchronised first port pins
    second_port_type second_sync_a;                   // first synchroniser stage, second port
    second_port_type second_sync;                     // synchronised second port pins

    // ------------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------------
    wire reg_index_type reg_index = reg_index_type'(adr_i[ADDR_WIDTH-1:2]); // word index
    wire logic req = cyc_i && stb_i;                                         // live request
    wire logic wr_lane = req && we_i && ack_o && sel_i[0];                   // write at ack edge
    wire logic hit_first_latch = reg_index == `IDX_FIRST_LATCH;              // first latch selected
    wire logic hit_second_latch = reg_index == `IDX_SECOND_LATCH;            // second latch selected
    wire logic hit_first_dir = reg_index == `IDX_FIRST_DIR;                  // first direction selected
    wire logic hit_second_dir = reg_index == `IDX_SECOND_DIR;                // second direction selected
    wire logic hit_first_inh = reg_index == `IDX_FIRST_INHIBIT;              // first inhibit selected
    wire logic hit_second_inh = reg_index == `IDX_SECOND_INHIBIT;            // second inhibit selected
    wire logic wr_first_latch = wr_lane && hit_first_latch;                  // first latch write
    wire logic wr_second_latch = wr_lane && hit_second_latch;                // second latch write
    wire logic wr_first_dir = wr_lane && hit_first_dir;                      // first direction write
    wire logic wr_second_dir = wr_lane && hit_second_dir;                    // second direction write
    wire logic wr_first_inh = wr_lane && hit_first_inh;                      // first inhibit write
    wire logic wr_second_inh = wr_lane && hit_second_inh;                    // second inhibit write
    wire logic rd_taken = req && !we_i && !ack_o; // read taken on this edge
    // no register selected: reads give zero, writes fall away
    wire logic hit_any = hit_first_latch || hit_second_latch || hit_first_dir ||
                         hit_second_dir || hit_first_inh || hit_second_inh;

    // ------------------------------------------------------------------------
    // read selection
    // ------------------------------------------------------------------------
    // upper second-port pin keeps its latch view while the oscillator owns it
    wire logic osc_owns_high = OSC3_OPTION;
    // output bits show the latch, input bits show the synchronised pin
    wire first_port_type first_data_view = (first_port_dir_bits & first_port_latch) |
                                           (~first_port_dir_bits & first_sync);
    wire second_port_type second_eff_dir = {second_port_dir[1] | osc_owns_high, second_port_dir[0]};
    wire second_port_type second_data_view = (second_eff_dir & second_port_latch) |
                                             (~second_eff_dir & second_sync);
    // second port upper bits are padded with zero; inhibit registers read zero
    wire logic [31:0] next_dat =
        hit_first_latch ? {24'h000000, first_data_view} :
        hit_second_latch ? {30'h00000000, second_data_view} :
        hit_first_dir ? {24'h000000, first_port_dir_bits} :
        hit_second_dir ? {30'h00000000, second_port_dir} :
        `BUS_READ_ZERO;

    // ------------------------------------------------------------------------
    // bus answer
    // ------------------------------------------------------------------------
    // one wait cycle, then ack for one cycle with registered read data
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= `BUS_READ_ZERO;
        end else begin
            ack_o <= req && !ack_o;
            dat_o <= rd_taken ? next_dat : `BUS_READ_ZERO;
        end
    end

    // ------------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------------
    // two flip-flops before any logic sees a pin level
    always_ff @(posedge clk_i) begin
        first_sync_a <= first_port_pins_i;
        first_sync <= first_sync_a;
        second_sync_a <= {second_port_pin_high_osc_out_i, second_port_pin_low_i};
        second_sync <= second_sync_a;
    end

    // ------------------------------------------------------------------------
    // data latches
    // ------------------------------------------------------------------------
    // latches hold their value through reset; writes land regardless of direction
    always_ff @(posedge clk_i) begin
        if (wr_first_latch) begin
            first_port_latch <= dat_i[7:0];
        end
        if (wr_second_latch) begin
            second_port_latch <= dat_i[1:0];
        end
    end

    // ------------------------------------------------------------------------
    // direction and inhibit registers
    // ------------------------------------------------------------------------
    // reset makes every pin but an oscillator-owned upper pin an input with its pulldown inhibit cleared
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            first_port_dir_bits <= `FIRST_DIR_RESET;
            second_port_dir <= `SECOND_DIR_RESET;
            first_port_inhibit_bits <= `FIRST_INHIBIT_RESET;
            second_port_inhibit <= `SECOND_INHIBIT_RESET;
        end else begin
            if (wr_first_dir) begin
                first_port_dir_bits <= dat_i[7:0];
            end
            if (wr_second_dir) begin
                second_port_dir <= dat_i[1:0];
            end
            if (wr_first_inh) begin
                first_port_inhibit_bits <= dat_i[7:0];
            end
            if (wr_second_inh) begin
                second_port_inhibit <= dat_i[1:0];
            end
        end
    end

    // ------------------------------------------------------------------------
    // pin drive
    // ------------------------------------------------------------------------
    // a set direction bit drives the latch value, a clear one releases the pin
    assign first_port_pins_o = first_port_latch;
    assign first_port_pins_oe_o = first_port_dir_bits;
    assign second_port_pin_low_o = second_port_latch[0];
    assign second_port_pin_low_oe_o = second_port_dir[0];
    // upper pin mirrors the lower one unless the oscillator owns it
    assign second_port_pin_high_osc_out_o = osc_owns_high ? osc_drive_i : second_port_latch[1];
    assign second_port_pin_high_osc_out_oe_o = osc_owns_high | second_port_dir[1];

    // ------------------------------------------------------------------------
    // pulldown control
    // ------------------------------------------------------------------------
    // pulldown only on inputs, only when optioned in, only when not inhibited
    wire logic pd_allowed = !PULLDOWN_MASK;
    assign first_port_pulldown_en_o = {8{pd_allowed}} & ~first_port_inhibit_bits &
                                      ~first_port_dir_bits;
    assign second_port_pulldown_en_o = {2{pd_allowed}} & ~second_port_inhibit &
                                       ~second_eff_dir;

    // ------------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------------
    a_dir_sets_drive: assert property (@(posedge clk_i) disable iff (rst_i)
        first_port_pins_oe_o == first_port_dir_bits && second_port_pin_low_oe_o == second_port_dir[0])
        else $error("output enable does not follow direction");

    a_dir_write_drive: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_first_dir |=> first_port_pins_oe_o == $past(dat_i[7:0]))
        else $error("direction write did not reach the output enables");

    a_reset_clears_regs: assert property (@(posedge clk_i)
        rst_i |=> first_port_pins_oe_o == 8'h00 && !second_port_pin_low_oe_o &&
                         first_port_inhibit_bits == 8'h00 && second_port_inhibit == 2'h0)
        else $error("reset left a direction or inhibit bit set");

    a_reset_pulldowns_on: assert property (@(posedge clk_i)
        rst_i && !PULLDOWN_MASK |=> first_port_pulldown_en_o == 8'hff)
        else $error("pulldowns not enabled after reset");

    a_latch_to_pin: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_first_latch |=> first_port_pins_o == $past(dat_i[7:0]))
        else $error("output pin does not follow latch write");

    a_read_mixed_view: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_o && $past(req && !we_i && hit_first_latch && !ack_o) |->
        dat_o[7:0] == (($past(first_port_dir_bits) & $past(first_port_latch)) |
                       (~$past(first_port_dir_bits) & $past(first_sync))))
        else $error("data read mixes latch and pin wrongly");

    a_output_no_pulldown: assert property (@(posedge clk_i) disable iff (rst_i)
        (first_port_pulldown_en_o & first_port_dir_bits) == 8'h00 &&
        (second_port_pulldown_en_o & second_port_dir) == 2'h0)
        else $error("pulldown active on an output pin");

    a_input_pulldown_rule: assert property (@(posedge clk_i) disable iff (rst_i)
        first_port_pulldown_en_o == ({8{!PULLDOWN_MASK}} & ~first_port_inhibit_bits & ~first_port_dir_bits))
        else $error("input pulldown does not match option and inhibit");

    a_input_write_holds: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_first_latch && first_port_dir_bits == 8'h00 && !wr_first_dir |=> first_port_pins_oe_o == 8'h00)
        else $error("latch write changed an input pin");

    a_inhibit_reads_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_o && $past(req && !we_i && (hit_first_inh || hit_second_inh)) |-> dat_o == `BUS_READ_ZERO)
        else $error("inhibit register read returned data");

    a_second_upper_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_o && $past(req && (hit_second_latch || hit_second_dir)) |-> dat_o[31:2] == 30'h00000000)
        else $error("second port unused bits read nonzero");

    a_osc_owns_pin: assert property (@(posedge clk_i) disable iff (rst_i)
        OSC3_OPTION |-> second_port_pin_high_osc_out_oe_o && second_port_pulldown_en_o[1] == 1'b0 &&
                        second_port_pin_high_osc_out_o == osc_drive_i)
        else $error("oscillator option does not own the upper pin");

    a_upper_like_lower: assert property (@(posedge clk_i) disable iff (rst_i)
        !OSC3_OPTION |-> second_port_pin_high_osc_out_oe_o == second_port_dir[1] &&
                         second_port_pulldown_en_o[1] == (!PULLDOWN_MASK && !second_port_inhibit[1] &&
                                                          !second_port_dir[1]))
        else $error("upper pin differs from lower pin behaviour");

    a_ack_single_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_o |=> !ack_o)
        else $error("acknowledge held longer than one cycle");

    // a fresh request is answered on the next edge
    a_ack_follows_req: assert property (@(posedge clk_i) disable iff (rst_i)
        req && !ack_o |=> ack_o)
        else $error("request not answered");

    // nothing is acknowledged unasked
    a_no_ack_unasked: assert property (@(posedge clk_i) disable iff (rst_i)
        !req |=> !ack_o)
        else $error("ack without request");

    // read data stays zero outside the ack cycle
    a_idle_data_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        !ack_o |-> dat_o == `BUS_READ_ZERO)
        else $error("read data outside ack");

    // reset drops a pending answer
    a_reset_ack_low: assert property (@(posedge clk_i)
        rst_i |=> !ack_o && dat_o == `BUS_READ_ZERO)
        else $error("reset left the answer up");

    // second direction takes the written bits
    a_second_dir_write: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_second_dir |=> second_port_dir == $past(dat_i[1:0]))
        else $error("second direction write lost");

    // first inhibit takes the written byte
    a_first_inh_write: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_first_inh |=> first_port_inhibit_bits == $past(dat_i[7:0]))
        else $error("first inhibit write lost");

    // second inhibit takes the written bits
    a_second_inh_write: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_second_inh |=> second_port_inhibit == $past(dat_i[1:0]))
        else $error("second inhibit write lost");

    // lower pin value follows its latch
    a_second_latch_pin: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_second_latch |=> second_port_pin_low_o == $past(dat_i[0]))
        else $error("low pin misses latch write");

    // upper pin value follows its latch when not owned
    a_upper_latch_pin: assert property (@(posedge clk_i) disable iff (rst_i)
        !OSC3_OPTION && wr_second_latch |=> second_port_pin_high_osc_out_o == $past(dat_i[1]))
        else $error("upper pin misses latch write");

    // direction holds while not written
    a_dir_held_idle: assert property (@(posedge clk_i) disable iff (rst_i)
        !rst_i && !wr_first_dir |=> first_port_dir_bits == $past(first_port_dir_bits))
        else $error("direction changed unwritten");

    // inhibit holds while not written
    a_inh_held_idle: assert property (@(posedge clk_i) disable iff (rst_i)
        !rst_i && !wr_first_inh |=> first_port_inhibit_bits == $past(first_port_inhibit_bits))
        else $error("inhibit changed unwritten");

    // first direction reads back
    a_read_dir_first: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_o && $past(rd_taken && hit_first_dir) |-> dat_o[7:0] == $past(first_port_dir_bits))
        else $error("first direction read wrong");

    // second direction reads back
    a_read_dir_second: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_o && $past(rd_taken && hit_second_dir) |-> dat_o[1:0] == $past(second_port_dir))
        else $error("second direction read wrong");

    // lower pin read: latch if output, pin if input
    a_read_low_view: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_o && $past(rd_taken && hit_second_latch) |->
        dat_o[0] == ($past(second_port_dir[0]) ? $past(second_port_latch[0]) : $past(second_sync[0])))
        else $error("low pin read wrong");

    // unmapped reads answer zero
    a_unmapped_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_o && $past(rd_taken && !hit_any) |-> dat_o == `BUS_READ_ZERO)
        else $error("unmapped read not zero");

    // a read leaves the registers alone
    a_read_no_side: assert property (@(posedge clk_i) disable iff (rst_i)
        rd_taken |=> second_port_dir == $past(second_port_dir) && second_port_inhibit == $past(second_port_inhibit))
        else $error("read changed a register");

    // input pins are never driven
    a_input_no_drive: assert property (@(posedge clk_i) disable iff (rst_i)
        (first_port_pins_oe_o & ~first_port_dir_bits) == 8'h00 &&
        !(second_port_pin_low_oe_o && !second_port_dir[0]))
        else $error("input pin driven");

    // a driven upper pin never has its pulldown on
    a_oe_pd_exclusive: assert property (@(posedge clk_i) disable iff (rst_i)
        !(second_port_pin_high_osc_out_oe_o && second_port_pulldown_en_o[1]))
        else $error("upper pin driven and pulled");

    // lower pin pulldown needs option, clear inhibit, input
    a_second_pd_rule: assert property (@(posedge clk_i) disable iff (rst_i)
        second_port_pulldown_en_o[0] == (!PULLDOWN_MASK && !second_port_inhibit[0] && !second_port_dir[0]))
        else $error("low pin pulldown wrong");

    // second port pulldowns come up on after reset, the upper one only without the oscillator option
    a_reset_second_pd: assert property (@(posedge clk_i)
        rst_i && !PULLDOWN_MASK |=> second_port_pulldown_en_o == {!OSC3_OPTION, 1'b1})
        else $error("second pulldowns not on after reset");

endmodule

// file: tb/board_model.sv
// board circuitry seen by one port: pin level from driver, outside source, pulldown or float
module board_model #(
    parameter int W = 8 // number of pins on this port
) (
    input wire logic clk_i,             // bench clock, used to move floating lines
    input wire logic [W-1:0] drive_i,   // value the controller drives
    input wire logic [W-1:0] oe_i,      // controller output enables
    input wire logic [W-1:0] pulldown_i, // controller pulldown enables
    input wire logic [W-1:0] ext_val_i, // value an outside source drives
    input wire logic [W-1:0] ext_en_i,  // outside source active on this pin
    output logic [W-1:0] level_o        // resolved pin level
);
    // -------------------------------------------------------------------------
    // resolution
    // -------------------------------------------------------------------------
    logic [W-1:0] float_q = '0; // level of an undriven, unpulled line

    // a floating line never holds its last value: it flips each cycle
    always_ff @(posedge clk_i) begin
        float_q <= ~level_o;
    end

    // controller first, then the outside source, then the pulldown, else float
    always_comb begin
        for (int i = 0; i < W; i++) begin
            level_o[i] = oe_i[i] ? drive_i[i] : ext_en_i[i] ? ext_val_i[i] : pulldown_i[i] ? 1'b0 : float_q[i];
        end
    end
endmodule

// file: tb/tb_top.sv
// self-checking bench for the two-port pin controller
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // -------------------------------------------------------------------------
    // signals
    // -------------------------------------------------------------------------
    logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
    logic [7:0] adr_i = 8'h00;
    logic [3:0] sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0, dat_o, rd;
    logic ack_o, low_o, low_oe, high_o, high_oe, osc_drive = 1'b0;
    logic [7:0] pins_o, oe_a, pd_a, lvl_a, ext_a = 8'h00, ext_en_a = 8'h00;
    logic [1:0] pd_b, lvl_b, ext_b = 2'h0, ext_en_b = 2'h0;
    int num_errors = 0, compares = 0;
    typedef struct {logic [7:0] adr; logic [7:0] wr; logic [7:0] exp;} row_type;
    row_type rows [9] = '{'{8'h10, 8'hff, 8'hff}, '{8'h00, 8'h3c, 8'h3c}, '{8'h14, 8'hff, 8'h03},
        '{8'h04, 8'hff, 8'h03}, '{8'h40, 8'hff, 8'h00}, '{8'h44, 8'hff, 8'h00}, '{8'h20, 8'h5a, 8'h00},
        '{8'h10, 8'ha5, 8'ha5}, '{8'h14, 8'h01, 8'h01}};

    always #20 clk_i = ~clk_i; // 25 MHz

    bidir_port_pulldown_ctrl #(.ADDR_WIDTH(8), .PULLDOWN_MASK(1'b0), .OSC3_OPTION(1'b0)) dut_u (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
        .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .first_port_pins_i(lvl_a),
        .first_port_pins_o(pins_o), .first_port_pins_oe_o(oe_a), .first_port_pulldown_en_o(pd_a),
        .second_port_pin_low_i(lvl_b[0]), .second_port_pin_low_o(low_o), .second_port_pin_low_oe_o(low_oe),
        .second_port_pin_high_osc_out_i(lvl_b[1]), .second_port_pin_high_osc_out_o(high_o),
        .second_port_pin_high_osc_out_oe_o(high_oe), .second_port_pulldown_en_o(pd_b), .osc_drive_i(osc_drive));
    board_model #(.W(8)) board_a (.clk_i(clk_i), .drive_i(pins_o), .oe_i(oe_a), .pulldown_i(pd_a),
        .ext_val_i(ext_a), .ext_en_i(ext_en_a), .level_o(lvl_a));
    board_model #(.W(2)) board_b (.clk_i(clk_i), .drive_i({high_o, low_o}), .oe_i({high_oe, low_oe}),
        .pulldown_i(pd_b), .ext_val_i(ext_b), .ext_en_i(ext_en_b), .level_o(lvl_b));

    // -------------------------------------------------------------------------
    // tasks
    // -------------------------------------------------------------------------
    // counts, then ends the run with the verdict
    task automatic wrap_up;
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // one compare, reported at once on mismatch
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one classic wishbone cycle, held until ack is sampled high
    task automatic wb(input logic we, input logic [7:0] adr, input logic [7:0] wd);
        int n = 0;
        @(posedge clk_i);
        cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= we; adr_i <= adr; dat_i <= {24'h0, wd}; sel_i <= 4'h1;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 16);
        rd = dat_o;
        cyc_i <= 1'b0; stb_i <= 1'b0; we_i <= 1'b0;
        if (ack_o !== 1'b1) begin
            num_errors++;
            wrap_up();
        end
    endtask

    // let register updates reach the pins
    task automatic settle;
        repeat (3) @(posedge clk_i);
        #1;
    endtask

    // -------------------------------------------------------------------------
    // main sequence
    // -------------------------------------------------------------------------
    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        settle();
        chk({oe_a, 6'h0, high_oe, low_oe}, 32'h0);
        chk({pd_a, 6'h0, pd_b}, 32'hff03);
        wb(1'b0, 8'h10, 8'h00); chk(rd, 32'h0);
        // plain register cases: write then read back
        foreach (rows[i]) begin
            wb(1'b1, rows[i].adr, rows[i].wr);
            wb(1'b0, rows[i].adr, 8'h00);
            chk(rd, {24'h0, rows[i].exp});
        end
        chk({28'h0, high_o, high_oe, low_o, low_oe}, 32'hb);
        // mixed directions on the first port with an outside source on inputs
        ext_a <= 8'hc3; ext_en_a <= 8'h5a;
        settle();
        chk({24'h0, oe_a}, 32'ha5);
        chk({24'h0, lvl_a & 8'ha5}, 32'h24);
        chk({24'h0, pd_a}, 32'h00);
        wb(1'b1, 8'h40, 8'h00); settle();
        chk({24'h0, pd_a}, 32'h5a);
        wb(1'b0, 8'h00, 8'h00); chk(rd, 32'h66);
        // latch written while input, then applied when made output
        wb(1'b1, 8'h10, 8'h00);
        wb(1'b1, 8'h00, 8'h0f); settle();
        chk({24'h0, oe_a}, 32'h00);
        wb(1'b0, 8'h00, 8'h00); chk(rd, 32'h42);
        ext_en_a <= 8'h00;
        wb(1'b1, 8'h10, 8'hff); settle();
        chk({24'h0, lvl_a}, 32'h0f);
        // second port pulldowns and input reads, upper pin like lower
        wb(1'b1, 8'h44, 8'h00);
        wb(1'b1, 8'h14, 8'h00); settle();
        chk({30'h0, pd_b}, 32'h3);
        wb(1'b1, 8'h44, 8'h02); settle();
        chk({30'h0, pd_b}, 32'h1);
        ext_b <= 2'b10; ext_en_b <= 2'b11;
        settle();
        wb(1'b0, 8'h04, 8'h00); chk(rd, 32'h2);
        // reset in mid-run returns all pins to inputs with pulldowns on
        @(posedge clk_i);
        rst_i <= 1'b1;
        @(posedge clk_i);
        rst_i <= 1'b0;
        settle();
        chk({oe_a, 6'h0, high_oe, low_oe}, 32'h0);
        chk({pd_a, 6'h0, pd_b}, 32'hff03);
        wb(1'b0, 8'h14, 8'h00); chk(rd, 32'h0);
        wrap_up();
    end
endmodule
